//--- sfdprc_consts.vh
// Constants for the parameter dword 16 and soft reset block
// Behaviour
// - Relative byte 6Bh reads 80h: no way to enter 4-byte addressing.
// - Bits 23:14 read 11_0000_0000b, byte 6Ah reads C0h: no exit method.
// - Soft reset only as 66h then 99h; reset support field reads 11_0000b.
// - Reset sequence is sent and decoded on current 1, 2 or 4 line width.
// - After power-up status register 1 holds last non-volatile written value.
// - Instruction 50h enables the following status register 1 write.
// - Byte 68h reads E8h, byte 69h reads 30h.
// - Accepted reset takes about 10 us; all commands rejected meanwhile.
`ifndef SFDPRC_CONSTS_VH
`define SFDPRC_CONSTS_VH

// ----------------------------------------
// Table bytes
// ----------------------------------------
`define SFDPRC_ADDR_B0    7'h68
`define SFDPRC_ADDR_B1    7'h69
`define SFDPRC_ADDR_B2    7'h6a
`define SFDPRC_ADDR_B3    7'h6b
`define SFDPRC_DATA_B0    8'he8
`define SFDPRC_DATA_B1    8'h30
`define SFDPRC_DATA_B2    8'hc0
`define SFDPRC_DATA_B3    8'h80

// ----------------------------------------
// Instructions
// ----------------------------------------
`define SFDPRC_CMD_RST_EN 8'h66
`define SFDPRC_CMD_RST    8'h99
`define SFDPRC_CMD_VWREN  8'h50
`define SFDPRC_CMD_WRSR   8'h01

// ----------------------------------------
// Widths and timing
// ----------------------------------------
`define SFDPRC_WID_1      2'h0
`define SFDPRC_WID_2      2'h1
`define SFDPRC_WID_4      2'h2
`define SFDPRC_CLK_MHZ    50
`define SFDPRC_T_RST_US   10

`endif

//--- sfdprc_top.v
// Dword 16 table readout, soft reset sequencer and status register 1 enable
`timescale 1ns/10ps
`default_nettype none
`include "sfdprc_consts.vh"

module sfdprc_top #(
	parameter RST_CYC = `SFDPRC_T_RST_US * `SFDPRC_CLK_MHZ
) (
	// Clock and reset
	input  wire       clk_i,
	input  wire       reset_i,
	// Serial lane from the host, one line group per strobe
	input  wire       cs_n_i,
	input  wire [1:0] width_i,
	input  wire       lane_vld_i,
	input  wire [3:0] lane_i,
	// Parameter table lookup
	input  wire       tbl_rd_i,
	input  wire [6:0] tbl_addr_i,
	output reg  [7:0] tbl_data_o,
	output reg        tbl_vld_o,
	// Status register 1 non-volatile copy and live value
	input  wire [7:0] sr1_nv_i,
	output reg  [7:0] sr1_o,
	output reg        sr1_wren_o,
	// Command decode
	output reg  [7:0] cmd_o,
	output reg        cmd_vld_o,
	output reg        busy_o
);

// ----------------------------------------
// Table lookup
// ----------------------------------------
function [7:0] tbl_byte;
	input [6:0] a;
	begin
		case (a)
			`SFDPRC_ADDR_B0: tbl_byte = `SFDPRC_DATA_B0;
			`SFDPRC_ADDR_B1: tbl_byte = `SFDPRC_DATA_B1;
			`SFDPRC_ADDR_B2: tbl_byte = `SFDPRC_DATA_B2;
			`SFDPRC_ADDR_B3: tbl_byte = `SFDPRC_DATA_B3;
			default:         tbl_byte = 8'h00;
		endcase
	end
endfunction

always @(posedge clk_i or posedge reset_i) begin
	if (reset_i) begin
		tbl_data_o <= 8'h00;
		tbl_vld_o  <= 1'b0;
	end else begin
		tbl_vld_o  <= tbl_rd_i;
		tbl_data_o <= tbl_rd_i ? tbl_byte(tbl_addr_i) : 8'h00;
	end
end

// ----------------------------------------
// Lane width decode
// ----------------------------------------
function [2:0] lane_step;
	input [1:0] w;
	begin
		case (w)
			`SFDPRC_WID_4: lane_step = 3'h4;
			`SFDPRC_WID_2: lane_step = 3'h2;
			default:       lane_step = 3'h1;
		endcase
	end
endfunction

// MSB first: older bits move up by one strobe
function [7:0] lane_shift;
	input [7:0] s;
	input [1:0] w;
	input [3:0] l;
	begin
		case (w)
			`SFDPRC_WID_4: lane_shift = {s[3:0], l};
			`SFDPRC_WID_2: lane_shift = {s[5:0], l[1:0]};
			default:       lane_shift = {s[6:0], l[0]};
		endcase
	end
endfunction

// ----------------------------------------
// Instruction shifter on 1, 2 or 4 lines
// ----------------------------------------
reg  [7:0] sh_q;
reg  [2:0] cnt_q;
reg        first_q;
wire [7:0] sh_d;
wire [3:0] cnt_sum;
wire       take;
wire       byte_done;

// Only the opcode byte of a frame is shifted; none while busy
assign sh_d      = lane_shift(sh_q, width_i, lane_i);
assign cnt_sum   = {1'b0, cnt_q} + {1'b0, lane_step(width_i)};
assign take      = lane_vld_i && !cs_n_i && first_q && !busy_o;
assign byte_done = take && cnt_sum[3];

always @(posedge clk_i or posedge reset_i) begin
	if (reset_i) begin
		sh_q    <= 8'h00;
		cnt_q   <= 3'h0;
		first_q <= 1'b0;
	end else if (cs_n_i) begin
		cnt_q   <= 3'h0;
		first_q <= 1'b1;
	end else if (take) begin
		sh_q  <= sh_d;
		cnt_q <= cnt_sum[2:0];
		if (cnt_sum[3])
			first_q <= 1'b0;
	end
end

// ----------------------------------------
// Opcode decode and report
// ----------------------------------------
wire op_rst_en = byte_done && (sh_d == `SFDPRC_CMD_RST_EN);
wire op_rst    = byte_done && (sh_d == `SFDPRC_CMD_RST);
wire op_vwren  = byte_done && (sh_d == `SFDPRC_CMD_VWREN);
wire op_wrsr   = byte_done && (sh_d == `SFDPRC_CMD_WRSR);

always @(posedge clk_i or posedge reset_i) begin
	if (reset_i) begin
		cmd_o     <= 8'h00;
		cmd_vld_o <= 1'b0;
	end else begin
		cmd_vld_o <= byte_done;
		if (byte_done)
			cmd_o <= sh_d;
	end
end

// ----------------------------------------
// Reset sequencer
// ----------------------------------------
localparam        ST_IDLE  = 2'h0;
localparam        ST_ARMED = 2'h1;
localparam        ST_PEND  = 2'h2;
localparam        ST_BUSY  = 2'h3;
localparam [31:0] RST_LOAD = RST_CYC - 1;

reg  [1:0]  st_q;
reg  [1:0]  st_d;
reg  [31:0] rcnt_q;
wire        rcnt_end;
wire        rst_done;

assign rcnt_end = (rcnt_q == 32'h0);
assign rst_done = (st_q == ST_BUSY) && rcnt_end;

// Reset runs from the end of the 99h frame, not from its last strobe
always @* begin
	st_d = st_q;
	case (st_q)
		ST_IDLE: begin
			if (op_rst_en)
				st_d = ST_ARMED;
		end
		ST_ARMED: begin
			if (op_rst)
				st_d = ST_PEND;
			else if (byte_done && !op_rst_en)
				st_d = ST_IDLE;
		end
		ST_PEND: begin
			if (cs_n_i)
				st_d = ST_BUSY;
		end
		ST_BUSY: begin
			if (rcnt_end)
				st_d = ST_IDLE;
		end
		default: begin
			st_d = ST_IDLE;
		end
	endcase
end

always @(posedge clk_i or posedge reset_i) begin
	if (reset_i) begin
		st_q   <= ST_IDLE;
		rcnt_q <= 32'h0;
		busy_o <= 1'b0;
	end else begin
		st_q   <= st_d;
		busy_o <= (st_d == ST_BUSY);
		if (st_q == ST_PEND)
			rcnt_q <= RST_LOAD;
		else if ((st_q == ST_BUSY) && !rcnt_end)
			rcnt_q <= rcnt_q - 32'h1;
	end
end

// ----------------------------------------
// Status register 1
// ----------------------------------------
// Async reset may only load constants, so the copy loads one edge later
reg boot_q;

always @(posedge clk_i or posedge reset_i) begin
	if (reset_i)
		boot_q <= 1'b1;
	else
		boot_q <= 1'b0;
end

always @(posedge clk_i or posedge reset_i) begin
	if (reset_i) begin
		sr1_o      <= 8'h00;
		sr1_wren_o <= 1'b0;
	end else begin
		if (boot_q || rst_done)
			sr1_o <= sr1_nv_i;
		if (st_d == ST_BUSY)
			sr1_wren_o <= 1'b0;
		else if (op_vwren)
			sr1_wren_o <= 1'b1;
		else if (op_wrsr)
			sr1_wren_o <= 1'b0;
	end
end

endmodule
`default_nettype wire

//--- sfdprc_properties.sv
// Checker for the table readout and the soft reset sequence
`timescale 1ns/10ps
`default_nettype none
module sfdprc_props #(parameter RST_CYC = 5) (
	input wire logic clk_i, reset_i, tbl_rd_i, tbl_vld_o, busy_o, cmd_vld_o,
	input wire logic sr1_wren_o,
	input wire logic [6:0] tbl_addr_i,
	input wire logic [7:0] tbl_data_o, sr1_nv_i, sr1_o, cmd_o
);
	int c_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	always @(posedge clk_i or posedge reset_i)
		c_q <= reset_i ? 0 : busy_o ? c_q + 1 : 0;
	chk_top_byte: assert property (tbl_rd_i && tbl_addr_i == 7'h6b |=>
		tbl_vld_o && tbl_data_o == 8'h80) else $error("byte 6b wrong");
	chk_exit_byte: assert property (tbl_rd_i && tbl_addr_i == 7'h6a |=>
		tbl_data_o == 8'hc0) else $error("byte 6a wrong");
	chk_low_bytes: assert property (tbl_rd_i && tbl_addr_i[6:1] == 6'h34
		|=> tbl_data_o == ($past(tbl_addr_i[0]) ? 8'h30 : 8'he8))
		else $error("byte 68 or 69 wrong");
	chk_busy_cause: assert property ($rose(busy_o) |-> cmd_o == 8'h99)
		else $error("busy without reset");
	chk_busy_len: assert property ($fell(busy_o) |-> c_q == RST_CYC)
		else $error("busy length wrong");
	chk_busy_mute: assert property (busy_o |-> !cmd_vld_o)
		else $error("command taken while busy");
	chk_sr1_load: assert property ($fell(busy_o) || $fell(reset_i) |->
		##[0:1] sr1_o == sr1_nv_i) else $error("sr1 not loaded");
	chk_wren_set: assert property (cmd_vld_o && cmd_o == 8'h50 |->
		##[0:1] sr1_wren_o) else $error("write enable not set");
	cover property ($rose(busy_o));
	cover property (tbl_vld_o);
	cover property ($rose(sr1_wren_o));
endmodule
bind sfdprc_top sfdprc_props #(.RST_CYC(RST_CYC)) chk_u (
	.clk_i(clk_i), .reset_i(reset_i), .tbl_rd_i(tbl_rd_i),
	.tbl_vld_o(tbl_vld_o), .busy_o(busy_o), .cmd_vld_o(cmd_vld_o),
	.sr1_wren_o(sr1_wren_o), .tbl_addr_i(tbl_addr_i),
	.tbl_data_o(tbl_data_o), .sr1_nv_i(sr1_nv_i), .sr1_o(sr1_o),
	.cmd_o(cmd_o));
`default_nettype wire

//--- sfdprc_host.sv
// Host model sending one-byte instruction frames
`timescale 1ns/10ps
`default_nettype none
module sfdprc_host (
	input  wire logic      clk_i,
	output var logic       cs_n_o = 1, vld_o = 0,
	output var logic [1:0] wid_o = 0,
	output var logic [3:0] lane_o = 0
);
	// Plain frames only, continuous read never entered
	task send(input logic [7:0] b, input logic [1:0] w);
		@(negedge clk_i) wid_o = w;
		cs_n_o = 0;
		for (int i = 8 - (1 << w); i >= 0; i -= 1 << w) begin
			@(negedge clk_i) vld_o = 1;
			lane_o = 4'(b >> i) & ~(4'hf << (1 << w));
		end
		@(negedge clk_i) vld_o = 0;
		lane_o = ~lane_o;
		cs_n_o = 1;
		@(negedge clk_i);
	endtask
endmodule
`default_nettype wire

//--- sfdprc_top_bench.sv
// Bench for the table readout and soft reset block
`timescale 1ns/10ps
`default_nettype none
module sfdprc_top_bench;
	logic clk_i = 0, reset_i = 1, tbl_rd_i = 0;
	logic [6:0] tbl_addr_i = 0;
	logic [7:0] sr1_nv_i = 8'h5c;
	wire cs_n_i, lane_vld_i, tbl_vld_o, sr1_wren_o, cmd_vld_o, busy_o;
	wire [1:0] width_i;
	wire [3:0] lane_i;
	wire [7:0] tbl_data_o, sr1_o, cmd_o;
	int n_errors = 0, n_compared = 0, cyc = 0, i, w;
	sfdprc_host host_u (.clk_i(clk_i), .cs_n_o(cs_n_i), .vld_o(lane_vld_i),
		.wid_o(width_i), .lane_o(lane_i));
	sfdprc_top #(.RST_CYC(5)) dut_u (.clk_i(clk_i), .reset_i(reset_i),
		.cs_n_i(cs_n_i), .width_i(width_i), .lane_vld_i(lane_vld_i),
		.lane_i(lane_i), .tbl_rd_i(tbl_rd_i), .tbl_addr_i(tbl_addr_i),
		.tbl_data_o(tbl_data_o), .tbl_vld_o(tbl_vld_o),
		.sr1_nv_i(sr1_nv_i), .sr1_o(sr1_o), .sr1_wren_o(sr1_wren_o),
		.cmd_o(cmd_o), .cmd_vld_o(cmd_vld_o), .busy_o(busy_o));
	initial forever #10 clk_i = ~clk_i;
	task ck(input logic [7:0] g, e);
		n_compared++;
		if (g !== e) begin
			$display("Error %0t got %h exp %h", $time, g, e);
			n_errors++;
		end
	endtask
	task report_and_stop;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task t_table;
		for (i = 0; i < 5; i++) begin
			@(negedge clk_i) tbl_rd_i = 1;
			tbl_addr_i = 7'(7'h68 + i);
			@(negedge clk_i) tbl_rd_i = 0;
			ck(tbl_data_o, 8'(40'h0080c030e8 >> 8 * i));
			ck({7'h0, tbl_vld_o}, 8'h01);
		end
		$display("table done");
	endtask
	task t_disarm;
		host_u.send(8'h66, 2'h1);
		host_u.send(8'h50, 2'h1);
		host_u.send(8'h99, 2'h1);
		repeat (3) @(negedge clk_i);
		ck(cmd_o, 8'h99);
		ck({7'h0, busy_o}, 8'h00);
		ck({7'h0, sr1_wren_o}, 8'h01);
		$display("disarm done");
	endtask
	task t_soft;
		for (w = 0; w < 3; w++) begin
			sr1_nv_i = 8'ha0 + 8'(w);
			host_u.send(8'h66, 2'(w));
			host_u.send(8'h99, 2'(w));
			for (i = 0; !busy_o && i < 3; i++) @(negedge clk_i);
			ck({7'h0, busy_o}, 8'h01);
			for (i = 0; busy_o && i < 9; i++) @(negedge clk_i);
			ck(8'(i), 8'h05);
			@(negedge clk_i);
			ck({7'h0, sr1_wren_o}, 8'h00);
			ck(sr1_o, 8'ha0 + 8'(w));
		end
		host_u.send(8'h66, 2'h2);
		host_u.send(8'h99, 2'h2);
		host_u.send(8'h50, 2'h2);
		ck(cmd_o, 8'h99);
		ck({7'h0, sr1_wren_o}, 8'h00);
		host_u.send(8'h50, 2'h2);
		ck({7'h0, sr1_wren_o}, 8'h01);
		$display("soft reset done");
	endtask
	initial begin
		repeat (20) @(negedge clk_i);
		reset_i = 0;
		@(negedge clk_i);
		ck(sr1_o, 8'h5c);
		t_table;
		t_disarm;
		t_soft;
		report_and_stop;
	end
	always @(posedge clk_i)
		if (++cyc == 3000) begin
			n_errors++;
			report_and_stop;
		end
endmodule
`default_nettype wire
